// [core/bemi_pkg.sv]
// Constants, register map and types for the banked external memory interface
package bemi_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // APB register map
    localparam int unsigned APB_AW = 12;
    localparam int unsigned APB_DW = 32;
    localparam logic [9:0]  CTRL_A_IDX   = 10'h074;
    localparam logic [9:0]  CTRL_B_IDX   = 10'h075;
    localparam logic [11:0] OFS_CTRL_A   = {CTRL_A_IDX, 2'b00};
    localparam logic [11:0] OFS_CTRL_B   = {CTRL_B_IDX, 2'b00};
    localparam logic [11:0] OFS_ACC_ADDR = 12'h000;
    localparam logic [11:0] OFS_ACC_DATA = 12'h004;
    localparam logic [11:0] OFS_ACC_CMD  = 12'h008;
    localparam logic [11:0] OFS_STATUS   = 12'h00C;
    localparam logic [11:0] OFS_PIN_OUT  = 12'h010;
    localparam logic [11:0] OFS_PIN_DIR  = 12'h014;
    localparam logic [11:0] OFS_PIN_IN   = 12'h018;
    localparam logic [11:0] OFS_BANK     = 12'h01C;

    ////////////////////////////////////////////////////////////////////////////
    // Control register fields and reset values
    localparam int unsigned CA_ENABLE_BIT = 7;
    localparam int unsigned CA_SRL_LO     = 4;
    localparam int unsigned CA_UWAIT_LO   = 2;
    localparam int unsigned CA_LWAIT_LO   = 0;
    localparam logic [7:0]  CTRL_A_RESET  = 8'h00;
    localparam logic [7:0]  CTRL_B_RESET  = 8'h00;
    localparam logic [7:0]  CTRL_B_RW_MASK = 8'h87;
    localparam int unsigned CMD_GO_BIT    = 0;
    localparam int unsigned CMD_WRITE_BIT = 1;
    localparam int unsigned ST_BUSY_BIT   = 0;
    localparam int unsigned ST_ADDR_ERR_BIT = 1;
    localparam int unsigned ST_OFF_ERR_BIT  = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Host address windows
    localparam logic [15:0] SRAM_BASE     = 16'h2200;
    localparam logic [15:0] SRAM_LAST     = 16'hA1FF;
    localparam logic [15:0] EXP_BASE      = 16'hA200;
    localparam logic [15:0] EXP_LAST      = 16'hFEFF;
    localparam logic [15:0] REG_BASE      = 16'hFF00;
    localparam logic [15:0] BANK_SEL_ADDR = 16'hFF00;

    ////////////////////////////////////////////////////////////////////////////
    // SRAM array shape
    localparam int unsigned BANK_W   = 4;
    localparam int unsigned BANK_AW  = 15;
    localparam int unsigned MEM_AW   = 19;
    localparam logic [3:0]  BANK_RESET = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Bus pin positions
    localparam int unsigned PIN_W     = 19;
    localparam int unsigned PIN_AD_LO = 0;
    localparam int unsigned PIN_HI_LO = 8;
    localparam int unsigned PIN_WR    = 16;
    localparam int unsigned PIN_RD    = 17;
    localparam int unsigned PIN_ALE   = 18;
    localparam logic [18:0] PIN_RESET = 19'h0_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle states
    typedef enum logic [2:0] {
        BEMI_IDLE   = 3'b000,
        BEMI_ADDR   = 3'b001,
        BEMI_STROBE = 3'b010,
        BEMI_WAIT   = 3'b011,
        BEMI_HOLD   = 3'b100
    } bemi_state_type;

endpackage

// [core/bemi_sram.sv]
// Byte-wide SRAM array of sixteen banks with registered read data
`timescale 1ns/10ps
module bemi_sram (
    // Clock
    input  wire logic                        sys_clk,
    // Access
    input  wire logic                        we,
    input  wire logic [bemi_pkg::MEM_AW-1:0] addr,
    input  wire logic [7:0]                  wdata,
    output logic      [7:0]                  rdata
);

    logic [7:0] mem [0:(2**bemi_pkg::MEM_AW)-1];

    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule

// [core/bemi_top.sv]
// External memory bus controller with board decode, SRAM banks and expansion bus
`timescale 1ns/10ps
//
// Behaviour
// - Enable bit 7 of control A switches the bus interface on; clear keeps it idle.
// - While enabled, the nineteen bus pins carry only bus signals, not general I/O.
// - Enable bit overrides pin direction settings for all bus pins.
// - Address space splits into two sectors at a point chosen by sector limit bits.
// - Sector limit bits all zero (reset) make the whole space one sector.
// - With a single sector every access uses the upper-sector wait field.
// - Control A bits 3:2 give the upper-sector wait-state count.
// - Control A bits 1:0 give the lower-sector wait-state count.
// - SRAM is sixteen banks of 32KB, one bank reachable at a time.
// - Active bank is decoded into host window 0x2200 through 0xA1FF.
// - A fixed 23K expansion region supports plain reads and writes at full speed.
// - Expansion bus gives 8-bit data, 16-bit address, read, write, enable, reset.
// - Board decode answers within a zero-wait bus cycle.
// - Exactly nineteen host lines form the external memory interface.
// - Strobes named with trailing asterisk are active low; others active high.
// - Multi-byte values are little endian, low byte at lowest address.
// - Bank zero is selected after reset; others only via the bank select register.
// - Top 256 bytes of host space hold board registers, bank select among them.
// - Low address and data share eight lines; latch enable marks the address phase.
module bemi_top (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst_n,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [bemi_pkg::APB_AW-1:0] paddr,
    input  wire logic [bemi_pkg::APB_DW-1:0] pwdata,
    output logic      [bemi_pkg::APB_DW-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Host bus pins
    input  wire logic [bemi_pkg::PIN_W-1:0]  pin_in,
    output logic      [bemi_pkg::PIN_W-1:0]  pin_out,
    output logic      [bemi_pkg::PIN_W-1:0]  pin_oe,
    // Expansion bus
    input  wire logic [7:0]                  exp_data_in,
    output logic      [7:0]                  exp_data_out,
    output logic                             exp_data_oe,
    output logic      [15:0]                 exp_addr,
    output logic                             exp_rd_n,
    output logic                             exp_wr_n,
    output logic                             exp_en_n,
    output logic                             exp_rst_n
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0]                   ctrl_a_reg;
    logic [7:0]                   ctrl_b_reg;
    logic [15:0]                  acc_addr_reg;
    logic [7:0]                   acc_data_reg;
    logic                         acc_write_reg;
    logic                         busy_reg;
    logic                         addr_err_reg;
    logic                         off_err_reg;
    logic [bemi_pkg::PIN_W-1:0]   gpio_out_reg;
    logic [bemi_pkg::PIN_W-1:0]   gpio_dir_reg;
    logic [1:0]                   wait_cnt_reg;
    logic [7:0]                   lat_lo_reg;
    logic [bemi_pkg::BANK_W-1:0]  bank_reg;
    bemi_pkg::bemi_state_type     state_reg;
    logic                         apb_wr;
    logic                         apb_rd;
    logic                         go_req;
    logic                         bus_en;
    logic [2:0]                   sector_limit_select;
    logic [1:0]                   upper_wait;
    logic [1:0]                   lower_wait;
    logic [1:0]                   wait_sel;
    logic                         mapped;
    logic [15:0]                  brd_addr;
    logic                         brd_sram;
    logic                         brd_exp;
    logic                         brd_reg;
    logic                         brd_rd;
    logic                         brd_wr;
    logic [7:0]                   brd_rdata;
    logic [7:0]                   sram_rdata;
    logic [14:0]                  sram_off;
    logic [15:0]                  sram_diff;
    logic [31:0]                  rd_word;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    assign apb_wr = psel && penable && pready && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    assign go_req = apb_wr && (paddr == bemi_pkg::OFS_ACC_CMD) && pwdata[bemi_pkg::CMD_GO_BIT];

    always_comb begin
        mapped  = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (paddr)
            bemi_pkg::OFS_CTRL_A:   rd_word = {24'h00_0000, ctrl_a_reg};
            bemi_pkg::OFS_CTRL_B:   rd_word = {24'h00_0000, ctrl_b_reg};
            bemi_pkg::OFS_ACC_ADDR: rd_word = {16'h0000, acc_addr_reg};
            bemi_pkg::OFS_ACC_DATA: rd_word = {24'h00_0000, acc_data_reg};
            bemi_pkg::OFS_ACC_CMD:  rd_word = {30'h0000_0000, acc_write_reg, 1'b0};
            bemi_pkg::OFS_STATUS:   rd_word = {29'h0000_0000, off_err_reg, addr_err_reg, busy_reg};
            bemi_pkg::OFS_PIN_OUT:  rd_word = {13'h0000, gpio_out_reg};
            bemi_pkg::OFS_PIN_DIR:  rd_word = {13'h0000, gpio_dir_reg};
            bemi_pkg::OFS_PIN_IN:   rd_word = {13'h0000, pin_in};
            bemi_pkg::OFS_BANK:     rd_word = {28'h000_0000, bank_reg};
            default:                mapped  = 1'b0;
        endcase
    end

    // One-cycle access phase; answer registered in the setup cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable && !pready;
            pslverr <= psel && !penable && !pready && !mapped;
            if (apb_rd) begin
                prdata <= rd_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_a_reg   <= bemi_pkg::CTRL_A_RESET;
            ctrl_b_reg   <= bemi_pkg::CTRL_B_RESET;
            acc_addr_reg <= 16'h0000;
            gpio_out_reg <= bemi_pkg::PIN_RESET;
            gpio_dir_reg <= bemi_pkg::PIN_RESET;
        end else if (apb_wr) begin
            unique case (paddr)
                bemi_pkg::OFS_CTRL_A:   ctrl_a_reg   <= pwdata[7:0];
                bemi_pkg::OFS_CTRL_B:   ctrl_b_reg   <= pwdata[7:0] & bemi_pkg::CTRL_B_RW_MASK;
                bemi_pkg::OFS_ACC_ADDR: acc_addr_reg <= pwdata[15:0];
                bemi_pkg::OFS_PIN_OUT:  gpio_out_reg <= pwdata[bemi_pkg::PIN_W-1:0];
                bemi_pkg::OFS_PIN_DIR:  gpio_dir_reg <= pwdata[bemi_pkg::PIN_W-1:0];
                default:                ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control field extraction and sector wait selection
    assign bus_en              = ctrl_a_reg[bemi_pkg::CA_ENABLE_BIT];
    assign sector_limit_select = ctrl_a_reg[bemi_pkg::CA_SRL_LO +: 3];
    assign upper_wait          = ctrl_a_reg[bemi_pkg::CA_UWAIT_LO +: 2];
    assign lower_wait          = ctrl_a_reg[bemi_pkg::CA_LWAIT_LO +: 2];

    // Lower sector lies below the limit; a zero limit leaves no lower sector
    always_comb begin
        if (acc_addr_reg[15:13] < sector_limit_select) begin
            wait_sel = lower_wait;
        end else begin
            wait_sel = upper_wait;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access data and status
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            acc_data_reg  <= 8'h00;
            acc_write_reg <= 1'b0;
            addr_err_reg  <= 1'b0;
            off_err_reg   <= 1'b0;
        end else begin
            if (apb_wr && paddr == bemi_pkg::OFS_ACC_DATA && !busy_reg) begin
                acc_data_reg <= pwdata[7:0];
            end else if (state_reg == bemi_pkg::BEMI_HOLD && !acc_write_reg) begin
                acc_data_reg <= brd_rdata;
            end
            if (apb_wr && paddr == bemi_pkg::OFS_ACC_CMD && !busy_reg) begin
                acc_write_reg <= pwdata[bemi_pkg::CMD_WRITE_BIT];
            end
            if (go_req && !busy_reg) begin
                addr_err_reg <= (acc_addr_reg < bemi_pkg::SRAM_BASE);
                off_err_reg  <= !bus_en;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle engine and pin drive
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg    <= bemi_pkg::BEMI_IDLE;
            busy_reg     <= 1'b0;
            wait_cnt_reg <= 2'b00;
            pin_out      <= bemi_pkg::PIN_RESET;
            pin_oe       <= bemi_pkg::PIN_RESET;
        end else if (!bus_en) begin
            state_reg <= bemi_pkg::BEMI_IDLE;
            busy_reg  <= 1'b0;
            pin_out   <= gpio_out_reg;
            pin_oe    <= gpio_dir_reg;
        end else begin
            pin_oe[bemi_pkg::PIN_HI_LO +: 8] <= 8'hFF;
            pin_oe[bemi_pkg::PIN_WR]         <= 1'b1;
            pin_oe[bemi_pkg::PIN_RD]         <= 1'b1;
            pin_oe[bemi_pkg::PIN_ALE]        <= 1'b1;
            unique case (state_reg)
                bemi_pkg::BEMI_IDLE: begin
                    pin_out[bemi_pkg::PIN_WR]        <= 1'b1;
                    pin_out[bemi_pkg::PIN_RD]        <= 1'b1;
                    pin_out[bemi_pkg::PIN_ALE]       <= 1'b0;
                    pin_oe[bemi_pkg::PIN_AD_LO +: 8] <= 8'h00;
                    if (go_req && acc_addr_reg >= bemi_pkg::SRAM_BASE) begin
                        state_reg                         <= bemi_pkg::BEMI_ADDR;
                        busy_reg                          <= 1'b1;
                        pin_out[bemi_pkg::PIN_ALE]        <= 1'b1;
                        pin_out[bemi_pkg::PIN_AD_LO +: 8] <= acc_addr_reg[7:0];
                        pin_out[bemi_pkg::PIN_HI_LO +: 8] <= acc_addr_reg[15:8];
                        pin_oe[bemi_pkg::PIN_AD_LO +: 8]  <= 8'hFF;
                    end
                end
                bemi_pkg::BEMI_ADDR: begin
                    state_reg                  <= bemi_pkg::BEMI_STROBE;
                    wait_cnt_reg               <= wait_sel;
                    pin_out[bemi_pkg::PIN_ALE] <= 1'b0;
                    if (acc_write_reg) begin
                        pin_out[bemi_pkg::PIN_AD_LO +: 8] <= acc_data_reg;
                        pin_out[bemi_pkg::PIN_WR]         <= 1'b0;
                    end else begin
                        pin_oe[bemi_pkg::PIN_AD_LO +: 8] <= 8'h00;
                        pin_out[bemi_pkg::PIN_RD]        <= 1'b0;
                    end
                end
                bemi_pkg::BEMI_STROBE: begin
                    state_reg <= (wait_cnt_reg == 2'b00) ? bemi_pkg::BEMI_HOLD : bemi_pkg::BEMI_WAIT;
                end
                bemi_pkg::BEMI_WAIT: begin
                    wait_cnt_reg <= wait_cnt_reg - 2'b01;
                    if (wait_cnt_reg == 2'b01) begin
                        state_reg <= bemi_pkg::BEMI_HOLD;
                    end
                end
                bemi_pkg::BEMI_HOLD: begin
                    state_reg                        <= bemi_pkg::BEMI_IDLE;
                    busy_reg                         <= 1'b0;
                    pin_out[bemi_pkg::PIN_WR]        <= 1'b1;
                    pin_out[bemi_pkg::PIN_RD]        <= 1'b1;
                    pin_oe[bemi_pkg::PIN_AD_LO +: 8] <= 8'h00;
                end
                default: begin
                    state_reg <= bemi_pkg::BEMI_IDLE;
                    busy_reg  <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Board side: address latch and window decode
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            lat_lo_reg <= 8'h00;
        end else if (bus_en && pin_out[bemi_pkg::PIN_ALE]) begin
            lat_lo_reg <= pin_out[bemi_pkg::PIN_AD_LO +: 8];
        end
    end

    assign brd_addr  = {pin_out[bemi_pkg::PIN_HI_LO +: 8], lat_lo_reg};
    assign brd_rd    = bus_en && !pin_out[bemi_pkg::PIN_RD];
    assign brd_wr    = bus_en && !pin_out[bemi_pkg::PIN_WR];
    assign brd_sram  = (brd_addr >= bemi_pkg::SRAM_BASE) && (brd_addr <= bemi_pkg::SRAM_LAST);
    assign brd_exp   = (brd_addr >= bemi_pkg::EXP_BASE) && (brd_addr <= bemi_pkg::EXP_LAST);
    assign brd_reg   = (brd_addr >= bemi_pkg::REG_BASE);
    assign sram_diff = brd_addr - bemi_pkg::SRAM_BASE;
    assign sram_off  = sram_diff[bemi_pkg::BANK_AW-1:0];

    always_comb begin
        brd_rdata = 8'h00;
        if (brd_sram) begin
            brd_rdata = sram_rdata;
        end else if (brd_exp) begin
            brd_rdata = exp_data_in;
        end else if (brd_reg && brd_addr == bemi_pkg::BANK_SEL_ADDR) begin
            brd_rdata = {4'h0, bank_reg};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Board side: bank select register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bank_reg <= bemi_pkg::BANK_RESET;
        end else if (brd_wr && brd_reg && brd_addr == bemi_pkg::BANK_SEL_ADDR) begin
            bank_reg <= pin_out[bemi_pkg::PIN_AD_LO +: bemi_pkg::BANK_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Board side: SRAM banks
    bemi_sram u_sram (
        .sys_clk (sys_clk),
        .we      (brd_wr && brd_sram),
        .addr    ({bank_reg, sram_off}),
        .wdata   (pin_out[bemi_pkg::PIN_AD_LO +: 8]),
        .rdata   (sram_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Board side: expansion bus
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            exp_addr     <= 16'h0000;
            exp_data_out <= 8'h00;
            exp_data_oe  <= 1'b0;
            exp_rd_n     <= 1'b1;
            exp_wr_n     <= 1'b1;
            exp_en_n     <= 1'b1;
            exp_rst_n    <= 1'b0;
        end else begin
            exp_rst_n    <= 1'b1;
            exp_addr     <= brd_addr;
            exp_data_out <= pin_out[bemi_pkg::PIN_AD_LO +: 8];
            exp_data_oe  <= brd_exp && brd_wr;
            exp_rd_n     <= !(brd_exp && brd_rd);
            exp_wr_n     <= !(brd_exp && brd_wr);
            exp_en_n     <= !(brd_exp && (brd_rd || brd_wr));
        end
    end

endmodule

// [dv/bemi_chk.sv]
// Checker for APB timing, host bus phases and expansion strobes
`timescale 1ns/10ps
module bemi_chk (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    // Host pins
    input wire logic [18:0] pin_out,
    input wire logic [18:0] pin_oe,
    // Expansion bus
    input wire logic [15:0] exp_addr,
    input wire logic        exp_rd_n,
    input wire logic        exp_wr_n,
    input wire logic        exp_en_n,
    input wire logic        exp_rst_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire ale  = pin_out[bemi_pkg::PIN_ALE];
    wire wr_n = pin_out[bemi_pkg::PIN_WR];
    wire rd_n = pin_out[bemi_pkg::PIN_RD];
    property p_rdy_after_setup; psel && !penable |=> pready; endproperty
    a_rdy_after_setup: assert property (p_rdy_after_setup) else $error("No ready after setup");
    property p_rdy_single; pready |=> !pready; endproperty
    a_rdy_single: assert property (p_rdy_single) else $error("Ready held too long");
    property p_ale_pulse; $rose(ale) |=> !ale; endproperty
    a_ale_pulse: assert property (p_ale_pulse) else $error("Latch enable not one cycle");
    property p_ale_addr; $rose(ale) |-> pin_oe[7:0] == 8'hff && wr_n && rd_n; endproperty
    a_ale_addr: assert property (p_ale_addr) else $error("Address phase not driven");
    property p_strobe_after_ale; $fell(ale) && pin_oe[16] |-> wr_n != rd_n; endproperty
    a_strobe_after_ale: assert property (p_strobe_after_ale) else $error("No single strobe");
    property p_exp_follow; $fell(exp_en_n) |-> $past(wr_n) == 1'b0 || $past(rd_n) == 1'b0; endproperty
    a_exp_follow: assert property (p_exp_follow) else $error("Expansion strobe uncaused");
    property p_exp_excl; !exp_rd_n |-> exp_wr_n && !exp_en_n; endproperty
    a_exp_excl: assert property (p_exp_excl) else $error("Expansion strobes clash");
    property p_exp_addr_hold; !exp_en_n && $past(exp_en_n) == 1'b0 |-> $stable(exp_addr); endproperty
    a_exp_addr_hold: assert property (p_exp_addr_hold) else $error("Expansion address moved");
    property p_exp_rst; rst_n |=> exp_rst_n; endproperty
    a_exp_rst: assert property (p_exp_rst) else $error("Expansion reset stuck");
endmodule
bind bemi_top bemi_chk i_bemi_chk (.sys_clk, .rst_n, .psel, .penable, .pready, .pin_out, .pin_oe,
    .exp_addr, .exp_rd_n, .exp_wr_n, .exp_en_n, .exp_rst_n);

// [dv/bemi_exp_model.sv]
// User expansion circuit answering with no wait-states
`timescale 1ns/10ps
module bemi_exp_model (
    // Clock
    input  wire logic        sys_clk,
    // Expansion bus
    input  wire logic [7:0]  exp_data_out,
    input  wire logic        exp_data_oe,
    input  wire logic [15:0] exp_addr,
    input  wire logic        exp_rd_n,
    input  wire logic        exp_wr_n,
    input  wire logic        exp_en_n,
    output logic      [7:0]  exp_data_in
);
    logic [7:0] mem [256];
    logic [7:0] last = 8'h00;
    always_ff @(posedge sys_clk) begin
        last <= exp_data_in;
        if (!exp_en_n && !exp_wr_n && exp_data_oe) begin
            mem[exp_addr[7:0]] <= exp_data_out;
        end
    end
    // Released bus toggles every cycle
    assign exp_data_in = (!exp_en_n && !exp_rd_n) ? mem[exp_addr[7:0]] : ~last;
endmodule

// [dv/bemi_top_bench.sv]
// Self-checking bench for the banked external memory interface
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module bemi_top_bench;
    logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic        exp_data_oe, exp_rd_n, exp_wr_n, exp_en_n, exp_rst_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [18:0] pin_in, pin_out, pin_oe, pin_float;
    logic [7:0]  exp_data_in, exp_data_out, ctrl, d;
    logic [15:0] exp_addr, a;
    int          mismatches, compares, seed, cnt, exp_len;
    int          lenq[$];
    bemi_top i_bemi_top (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .pin_in, .pin_out, .pin_oe, .exp_data_in, .exp_data_out, .exp_data_oe, .exp_addr, .exp_rd_n, .exp_wr_n,
        .exp_en_n, .exp_rst_n);
    bemi_exp_model i_bemi_exp_model (.sys_clk, .exp_data_out, .exp_data_oe, .exp_addr, .exp_rd_n, .exp_wr_n,
        .exp_en_n, .exp_data_in);
    assign pin_in = (pin_out & pin_oe) | (pin_float & ~pin_oe);
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) pin_float <= ~pin_float;
    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic bound(input int n);
        if (n >= 20) begin
            mismatches++;
            conclude();
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        bound(n);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] ad, input logic [31:0] e);
        apb(1'b0, ad, 32'h0000_0000);
        `CHK(rd, e)
    endtask
    // Expected wait-state count from the wait fields and sector split
    function automatic int wt(input logic [15:0] ad);
        return (ctrl[6:4] != 3'h0 && ad[15:13] < ctrl[6:4]) ? ctrl[1:0] : ctrl[3:2];
    endfunction
    task automatic cyc(input logic w, input logic [15:0] ad, input logic [7:0] wd);
        int n;
        n = 0;
        lenq.push_back(wt(ad) + 2);
        apb(1'b1, bemi_pkg::OFS_ACC_ADDR, {16'h0000, ad});
        apb(1'b1, bemi_pkg::OFS_ACC_DATA, {24'h00_0000, wd});
        apb(1'b1, bemi_pkg::OFS_ACC_CMD, {30'h0000_0000, w, 1'b1});
        do begin
            apb(1'b0, bemi_pkg::OFS_STATUS, 32'h0000_0000);
            n++;
        end while (rd[0] !== 1'b0 && n < 20);
        bound(n);
        apb(1'b0, bemi_pkg::OFS_ACC_DATA, 32'h0000_0000);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Strobe watcher: low-strobe length against the oldest note
    always @(posedge sys_clk) begin
        if (pin_oe[16] === 1'b1 && (pin_out[16] === 1'b0 || pin_out[17] === 1'b0)) begin
            cnt++;
        end else if (cnt != 0) begin
            exp_len = lenq.pop_front();
            `CHK(cnt, exp_len)
            cnt = 0;
        end
    end
    initial begin
        {seed, mismatches, compares, cnt, ctrl, psel, penable, pwrite, paddr, pwdata} = {32'd64774, 96'h0, 55'h0};
        rst_n = 1'b0;
        pin_float = 19'h5_5555;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        rchk(bemi_pkg::OFS_CTRL_A, 32'h0000_0000);
        rchk(bemi_pkg::OFS_BANK, 32'h0000_0000);
        apb(1'b1, bemi_pkg::OFS_CTRL_B, 32'h0000_00FF);
        rchk(bemi_pkg::OFS_CTRL_B, 32'h0000_0087);
        apb(1'b1, bemi_pkg::OFS_CTRL_B, 32'h0000_0000);
        apb(1'b0, 12'h100, 32'h0000_0000);
        `CHK({err, rd}, {1'b1, 32'h0000_0000})
        apb(1'b1, bemi_pkg::OFS_PIN_OUT, {13'h0000, 3'b011, 16'($random(seed))});
        apb(1'b1, bemi_pkg::OFS_PIN_DIR, 32'h0007_FFFF);
        @(posedge sys_clk);
        `CHK(pin_out[17:16], 2'b11)
        apb(1'b1, bemi_pkg::OFS_ACC_ADDR, 32'h0000_2200);
        apb(1'b1, bemi_pkg::OFS_ACC_CMD, 32'h0000_0001);
        rchk(bemi_pkg::OFS_STATUS, 32'h0000_0004);
        apb(1'b1, bemi_pkg::OFS_PIN_DIR, 32'h0000_0000);
        ctrl = 8'h80;
        apb(1'b1, bemi_pkg::OFS_CTRL_A, {24'h00_0000, ctrl});
        repeat (2) @(posedge sys_clk);
        `CHK({pin_oe[18:16], pin_out[18:16]}, 6'b111_011)
        apb(1'b1, bemi_pkg::OFS_ACC_ADDR, 32'h0000_1000);
        apb(1'b1, bemi_pkg::OFS_ACC_CMD, 32'h0000_0001);
        rchk(bemi_pkg::OFS_STATUS, 32'h0000_0002);
        for (int i = 0; i < 8; i++) begin
            ctrl = {1'b1, (i < 4) ? 3'd0 : 3'd3, 4'($random(seed))};
            apb(1'b1, bemi_pkg::OFS_CTRL_A, {24'h00_0000, ctrl});
            a = {i[0] ? 8'h90 : 8'h22, 8'($random(seed))};
            d = 8'($random(seed));
            cyc(1'b1, a, d);
            cyc(1'b0, a, 8'h00);
            `CHK(rd[7:0], d)
        end
        ctrl = 8'h80;
        apb(1'b1, bemi_pkg::OFS_CTRL_A, {24'h00_0000, ctrl});
        cyc(1'b1, bemi_pkg::BANK_SEL_ADDR, 8'h05);
        rchk(bemi_pkg::OFS_BANK, 32'h0000_0005);
        cyc(1'b1, 16'hA1FF, 8'hC3);
        cyc(1'b1, bemi_pkg::BANK_SEL_ADDR, 8'h00);
        cyc(1'b1, 16'hA1FF, 8'h3C);
        cyc(1'b1, bemi_pkg::BANK_SEL_ADDR, 8'h05);
        cyc(1'b0, 16'hA1FF, 8'h00);
        `CHK(rd[7:0], 8'hC3)
        a = 16'hA200 | 16'($random(seed) & 32'h0FFF);
        d = 8'($random(seed));
        cyc(1'b1, a, d);
        `CHK(i_bemi_exp_model.mem[a[7:0]], d)
        cyc(1'b0, a, 8'h00);
        `CHK(rd[7:0], d)
        repeat (2) @(posedge sys_clk);
        `CHK(lenq.size(), 0)
        conclude();
    end
endmodule
